//--- ufc_map.vh
`ifndef UFC_MAP_VH
`define UFC_MAP_VH
// What this block does
// - Direction polarity picks transmit/receive pin levels
// - Transmitter drives direction pin only when owning
// - Direction select: zero RTS, one DTR
// - Transmitter off bit keeps transmitter disabled
// - Receiver off bit keeps receiver disabled
// - Multidrop enable selects RS-485 versus RS-232
// - Level wake: no sleep while rx low
// - Edge wake: sleep anyway, wake on toggle
// - Flow swap moves flow control to DTR/DSR
// - Soft restart resets all but the APB port and pin synchronisers, then self-clears
// - Software reset lasts four reference clocks
// - Timing zero: interrupt on below-trigger or empty
// - Timing one: empty waits for stop bit
// - Pin reset and software reset load identical register values
// - Event status resets to one, no pending
// - Line flags reset with transmitter-empty bits set
// - Modem status shows live inputs, deltas zero
// - Reset outputs: TX/RTS/DTR high, event low, released
// - Turnaround countdown in bit times before receive

`define UFC_IDX_MASK      6'd0
`define UFC_IDX_QUEUE     6'd1
`define UFC_IDX_EVSRC     6'd2
`define UFC_IDX_FRAME     6'd3
`define UFC_IDX_MOUT      6'd4
`define UFC_IDX_LINE      6'd5
`define UFC_IDX_MIN       6'd6
`define UFC_IDX_SCRATCH   6'd7
`define UFC_IDX_EXTRA     6'd8
`define UFC_IDX_FLOW      6'd9
`define UFC_IDX_TXTRIG    6'd10
`define UFC_IDX_RXTRIG    6'd11
`define UFC_IDX_PRESC     6'd12
`define UFC_IDX_TURN      6'd13
`define UFC_IDX_FC2       6'd14
`define UFC_IDX_FC1       6'd15
`define UFC_IDX_STATUS    6'd16
`define UFC_NUM_CFG       16

`define UFC_FC2_MULTIDROP 0
`define UFC_FC2_RX_OFF    1
`define UFC_FC2_TX_OFF    2
`define UFC_FC2_DIR_SEL   3
`define UFC_FC2_TX_OWNS   4
`define UFC_FC2_DIR_POL   5
`define UFC_FC1_TXE_TIME  0
`define UFC_FC1_SOFT      1
`define UFC_FC1_SWAP      2
`define UFC_FC1_WAKE_EDGE 4
`define UFC_MASK_TXE      1
`define UFC_MOUT_DTR      0
`define UFC_MOUT_RTS      1
`define UFC_FLOW_AUTO_RTS 6
`define UFC_FLOW_AUTO_CTS 7
`define UFC_LINE_TEMT     6
`define UFC_LINE_THRE     5

`define UFC_RST_ZERO      8'h00
`define UFC_RST_SCRATCH   8'h01
`define UFC_EVSRC_IDLE    8'h01
`define UFC_EVSRC_TXE     8'h02
`define UFC_LINE_RST      8'h60
`define UFC_WMASK_ALL     8'hFF
`define UFC_WMASK_NONE    8'h00
`define UFC_WMASK_FC2     8'h3F
`define UFC_WMASK_FC1     8'h15
`define UFC_WMASK_PRESC   8'h0F
`define UFC_SRST_CYCLES   3'd4
`define UFC_SYNC_SETTLE   2'd3
`endif

//--- ufc_sync.v
`timescale 1ns/100ps
module ufc_sync #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 1'b1
) (
  input  wire             sys_clk_i,
  input  wire             resetn_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // Idle-high pins reset to their idle level
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      meta_q <= {WIDTH{RESET_VAL}};
      sync_q <= {WIDTH{RESET_VAL}};
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // ufc_sync

//--- ufc_turnaround.v
`timescale 1ns/100ps
module ufc_turnaround (
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       enable_i,
  input  wire       tx_active_i,
  input  wire       bit_tick_i,
  input  wire [7:0] delay_i,
  output wire       hold_o
);
  reg [7:0] count_q;
  reg       active_prev_q;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_q       <= 8'h00;
      active_prev_q <= 1'b0;
    end else if (ce_i) begin
      active_prev_q <= tx_active_i;
      if (!enable_i || tx_active_i)
        count_q <= 8'h00;
      else if (active_prev_q)
        count_q <= delay_i;
      else if (bit_tick_i && count_q != 8'h00)
        count_q <= count_q - 8'h01;
    end
  end

  // Direction stays at transmit level until the count runs out
  assign hold_o = (count_q != 8'h00);
endmodule // ufc_turnaround

//--- ufc_top.v
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "ufc_map.vh"
module ufc_top (
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        core_txd_i,
  input  wire        tx_active_i,
  input  wire        tx_shift_empty_i,
  input  wire        tx_fifo_empty_i,
  input  wire        tx_below_trig_i,
  input  wire        bit_tick_i,
  input  wire        sleep_req_i,
  input  wire        rx_flow_stop_i,
  input  wire        rx_i,
  input  wire        cts_n_i,
  input  wire        dsr_n_i,
  input  wire        dcd_n_i,
  input  wire        ri_n_i,
  output wire        txd_o,
  output wire        rts_n_o,
  output wire        dtr_n_o,
  output wire        host_event_o,
  output wire        irq_n_o,
  output wire        irq_n_oe_o,
  output wire        tx_enable_o,
  output wire        rx_enable_o,
  output wire        core_reset_o,
  output wire        tx_flow_ok_o,
  output wire        sleep_o
);

  function is_rw;
    input integer i;
    begin
      is_rw = !(i == `UFC_IDX_EVSRC || i == `UFC_IDX_LINE || i == `UFC_IDX_MIN);
    end
  endfunction

  function [7:0] rst_val;
    input integer i;
    begin
      rst_val = (i == `UFC_IDX_SCRATCH) ? `UFC_RST_SCRATCH : `UFC_RST_ZERO;
    end
  endfunction

  function [7:0] wr_mask;
    input integer i;
    begin
      case (i)
        `UFC_IDX_FC2:   wr_mask = `UFC_WMASK_FC2;
        `UFC_IDX_FC1:   wr_mask = `UFC_WMASK_FC1;
        `UFC_IDX_PRESC: wr_mask = `UFC_WMASK_PRESC;
        default:        wr_mask = `UFC_WMASK_ALL;
      endcase
    end
  endfunction

  // Soft restart sequencer and the combined internal reset
  reg  [2:0] srst_cnt_q;
  wire       srst_busy = (srst_cnt_q != 3'd0);
  wire       int_rst   = !resetn_i || srst_busy;
  wire       int_rst_n = !int_rst;

  // APB slave: one wait state so read data leaves a flop
  reg        pready_q;
  reg        pslverr_q;
  reg [31:0] prdata_q;
  wire       access   = psel_i && penable_i;
  wire [5:0] idx      = paddr_i[7:2];
  wire       unmapped = (paddr_i[1:0] != 2'b00) || (idx > `UFC_IDX_STATUS);
  wire       fire     = ce_i && access && pready_q;
  wire       wr_fire  = fire && pwrite_i && !pslverr_q && pstrb_i[0];
  wire       rd_fire  = fire && !pwrite_i && !pslverr_q;
  reg  [7:0] rd_byte;

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_q <= access && !pready_q;
      if (access && !pready_q) begin
        pslverr_q <= unmapped;
        prdata_q  <= unmapped ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready_o  = pready_q;
  assign pslverr_o = pready_q && pslverr_q;
  assign prdata_o  = prdata_q;

  // Software-written registers, one flop byte per read/write index
  wire [8*`UFC_NUM_CFG-1:0] cfg_flat;
  genvar gi;
  generate
    for (gi = 0; gi < `UFC_NUM_CFG; gi = gi + 1) begin : g_cfg
      if (is_rw(gi)) begin : g_rw
        reg [7:0] val_q;
        always @(posedge sys_clk_i) begin
          if (int_rst)
            val_q <= rst_val(gi);
          else if (wr_fire && {26'd0, idx} == gi)
            val_q <= pwdata_i[7:0] & wr_mask(gi);
        end
        assign cfg_flat[8*gi +: 8] = val_q;
      end else begin : g_ro
        assign cfg_flat[8*gi +: 8] = 8'h00;
      end
    end
  endgenerate

  wire [7:0] mask_r  = cfg_flat[8*`UFC_IDX_MASK +: 8];
  wire [7:0] mout_r  = cfg_flat[8*`UFC_IDX_MOUT +: 8];
  wire [7:0] flow_r  = cfg_flat[8*`UFC_IDX_FLOW +: 8];
  wire [7:0] turn_r  = cfg_flat[8*`UFC_IDX_TURN +: 8];
  wire [7:0] fc2_r   = cfg_flat[8*`UFC_IDX_FC2 +: 8];
  wire [7:0] fc1_r   = cfg_flat[8*`UFC_IDX_FC1 +: 8];

  wire multidrop = fc2_r[`UFC_FC2_MULTIDROP];
  wire tx_owns   = fc2_r[`UFC_FC2_TX_OWNS];
  wire dir_sel   = fc2_r[`UFC_FC2_DIR_SEL];
  wire dir_pol   = fc2_r[`UFC_FC2_DIR_POL];
  wire tx_off    = fc2_r[`UFC_FC2_TX_OFF];
  wire rx_off    = fc2_r[`UFC_FC2_RX_OFF];
  wire txe_late  = fc1_r[`UFC_FC1_TXE_TIME];
  wire swap      = fc1_r[`UFC_FC1_SWAP];
  wire wake_edge = fc1_r[`UFC_FC1_WAKE_EDGE];

  // The self-clear is timed here, not by software
  always @(posedge sys_clk_i) begin
    if (!resetn_i)
      srst_cnt_q <= 3'd0;
    else if (ce_i) begin
      if (srst_busy)
        srst_cnt_q <= srst_cnt_q - 3'd1;
      else if (wr_fire && idx == `UFC_IDX_FC1 && pwdata_i[`UFC_FC1_SOFT])
        srst_cnt_q <= `UFC_SRST_CYCLES;
    end
  end

  // Pin inputs cross into the clock domain first
  wire [4:0] pins_s;
  ufc_sync #(
    .WIDTH     (5),
    .RESET_VAL (1'b1)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .async_i   ({rx_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .sync_o    (pins_s)
  );
  wire       rx_s  = pins_s[4];
  wire [3:0] live  = ~pins_s[3:0];
  wire       cts_s = live[0];
  wire       dsr_s = live[1];

  // Modem input status: live levels plus sticky change bits
  reg  [3:0] live_prev_q;
  reg  [3:0] delta_q;
  wire [3:0] change = {live[3] ^ live_prev_q[3], live_prev_q[2] & !live[2],
                       live[1] ^ live_prev_q[1], live[0] ^ live_prev_q[0]};
  wire       msr_rd = rd_fire && idx == `UFC_IDX_MIN;

  // Synchroniser shows idle levels just after a pin reset
  reg  [1:0] settle_q;
  always @(posedge sys_clk_i) begin
    if (!resetn_i)
      settle_q <= `UFC_SYNC_SETTLE;
    else if (ce_i && settle_q != 2'd0)
      settle_q <= settle_q - 2'd1;
  end

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      live_prev_q <= live;
      delta_q     <= 4'h0;
    end else if (ce_i) begin
      live_prev_q <= live;
      // Only reported changes clear; later ones survive the read
      delta_q <= (msr_rd ? (delta_q & ~prdata_q[3:0]) : delta_q) |
                 ((settle_q != 2'd0) ? 4'h0 : change);
    end
  end

  // Line flags carry the transmitter-empty pair
  reg [7:0] line_q;
  always @(posedge sys_clk_i) begin
    if (int_rst)
      line_q <= `UFC_LINE_RST;
    else if (ce_i) begin
      line_q                 <= 8'h00;
      line_q[`UFC_LINE_THRE] <= tx_fifo_empty_i;
      line_q[`UFC_LINE_TEMT] <= tx_fifo_empty_i && tx_shift_empty_i;
    end
  end

  // Transmit-empty event and the event source status
  wire empty_hit  = txe_late ? (tx_fifo_empty_i && tx_shift_empty_i)
                             : tx_fifo_empty_i;
  wire txe_cond   = tx_below_trig_i || empty_hit;
  reg  txe_prev_q;
  reg  pend_q;
  wire txe_rise   = txe_cond && !txe_prev_q;
  wire evsrc_rd   = rd_fire && idx == `UFC_IDX_EVSRC;
  // A read that returned idle must not clear a late event
  wire evsrc_seen = |(prdata_q[7:0] & `UFC_EVSRC_TXE);

  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      txe_prev_q <= 1'b0;
      pend_q     <= 1'b0;
    end else if (ce_i) begin
      txe_prev_q <= txe_cond;
      if (txe_rise && mask_r[`UFC_MASK_TXE])
        pend_q <= 1'b1;
      else if ((evsrc_rd && evsrc_seen) || !mask_r[`UFC_MASK_TXE])
        pend_q <= 1'b0;
    end
  end

  wire [7:0] evsrc = pend_q ? `UFC_EVSRC_TXE : `UFC_EVSRC_IDLE;

  // Sleep entry and wake-up on the receive pin
  reg rx_prev_q;
  reg sleep_q;
  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      rx_prev_q <= 1'b1;
      sleep_q   <= 1'b0;
    end else if (ce_i) begin
      rx_prev_q <= rx_s;
      if (!sleep_q) begin
        if (sleep_req_i && (wake_edge || rx_s))
          sleep_q <= 1'b1;
      end else if (!sleep_req_i) begin
        sleep_q <= 1'b0;
      end else if (wake_edge) begin
        if (rx_s != rx_prev_q)
          sleep_q <= 1'b0;
      end else if (!rx_s) begin
        sleep_q <= 1'b0;
      end
    end
  end

  // Direction control with turnaround hold
  wire turn_hold;
  ufc_turnaround u_turn (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (int_rst_n),
    .ce_i        (ce_i),
    .enable_i    (multidrop),
    .tx_active_i (tx_active_i),
    .bit_tick_i  (bit_tick_i),
    .delay_i     (turn_r),
    .hold_o      (turn_hold)
  );

  // Bridge the clock between busy falling and the count loading
  reg  tx_busy_prev_q;
  always @(posedge sys_clk_i) begin
    if (int_rst)
      tx_busy_prev_q <= 1'b0;
    else if (ce_i)
      tx_busy_prev_q <= tx_active_i;
  end
  wire turn_bridge = multidrop && tx_busy_prev_q && (turn_r != 8'h00);
  wire dir_tx    = tx_active_i || turn_hold || turn_bridge;
  wire dir_level = dir_tx ? dir_pol : !dir_pol;
  wire dir_drive = multidrop && tx_owns;

  // Ordinary modem outputs, with flow stop on the chosen pin
  wire auto_rts  = flow_r[`UFC_FLOW_AUTO_RTS];
  wire auto_cts  = flow_r[`UFC_FLOW_AUTO_CTS];
  wire flow_n    = auto_rts && rx_flow_stop_i;
  wire rts_plain = !mout_r[`UFC_MOUT_RTS] || (flow_n && !swap);
  wire dtr_plain = !mout_r[`UFC_MOUT_DTR] || (flow_n && swap);
  wire rts_d     = (dir_drive && !dir_sel) ? dir_level : rts_plain;
  wire dtr_d     = (dir_drive && dir_sel) ? dir_level : dtr_plain;
  wire tx_en     = !tx_off && !int_rst;

  reg txd_q;
  reg rts_q;
  reg dtr_q;
  reg evt_q;
  always @(posedge sys_clk_i) begin
    if (int_rst) begin
      txd_q <= 1'b1;
      rts_q <= 1'b1;
      dtr_q <= 1'b1;
      evt_q <= 1'b0;
    end else if (ce_i) begin
      txd_q <= tx_en ? core_txd_i : 1'b1;
      rts_q <= rts_d;
      dtr_q <= dtr_d;
      evt_q <= pend_q;
    end
  end

  assign txd_o        = txd_q;
  assign rts_n_o      = rts_q;
  assign dtr_n_o      = dtr_q;
  assign host_event_o = evt_q;
  assign irq_n_o      = 1'b0;
  assign irq_n_oe_o   = evt_q;
  assign tx_enable_o  = tx_en;
  assign rx_enable_o  = !rx_off && !int_rst;
  assign core_reset_o = int_rst;
  assign tx_flow_ok_o = !auto_cts || (swap ? dsr_s : cts_s);
  assign sleep_o      = sleep_q;

  // Read multiplexer
  always @* begin
    case (idx)
      `UFC_IDX_EVSRC:  rd_byte = evsrc;
      `UFC_IDX_LINE:   rd_byte = line_q;
      `UFC_IDX_MIN:    rd_byte = {live, delta_q};
      `UFC_IDX_FC1:    rd_byte = fc1_r | {6'h00, srst_busy, 1'b0};
      `UFC_IDX_STATUS: rd_byte = {4'h0, dir_tx, sleep_q, !rx_off, !tx_off};
      `UFC_IDX_MASK:    rd_byte = cfg_flat[8*`UFC_IDX_MASK +: 8];
      `UFC_IDX_QUEUE:   rd_byte = cfg_flat[8*`UFC_IDX_QUEUE +: 8];
      `UFC_IDX_FRAME:   rd_byte = cfg_flat[8*`UFC_IDX_FRAME +: 8];
      `UFC_IDX_MOUT:    rd_byte = cfg_flat[8*`UFC_IDX_MOUT +: 8];
      `UFC_IDX_SCRATCH: rd_byte = cfg_flat[8*`UFC_IDX_SCRATCH +: 8];
      `UFC_IDX_EXTRA:   rd_byte = cfg_flat[8*`UFC_IDX_EXTRA +: 8];
      `UFC_IDX_FLOW:    rd_byte = cfg_flat[8*`UFC_IDX_FLOW +: 8];
      `UFC_IDX_TXTRIG:  rd_byte = cfg_flat[8*`UFC_IDX_TXTRIG +: 8];
      `UFC_IDX_RXTRIG:  rd_byte = cfg_flat[8*`UFC_IDX_RXTRIG +: 8];
      `UFC_IDX_PRESC:   rd_byte = cfg_flat[8*`UFC_IDX_PRESC +: 8];
      `UFC_IDX_TURN:    rd_byte = cfg_flat[8*`UFC_IDX_TURN +: 8];
      `UFC_IDX_FC2:     rd_byte = cfg_flat[8*`UFC_IDX_FC2 +: 8];
      default:         rd_byte = 8'h00;
    endcase
  end
endmodule // ufc_top

//--- ufc_line_model.sv
`timescale 1ns/100ps
module ufc_line_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] data_i,
  output wire logic       txd_o,
  output wire logic       active_o,
  output wire logic       tick_o
);
  // Bit tick runs free, as a baud generator never stops
  logic [1:0]  div_q  = 2'h0;
  logic [10:0] sh_q   = 11'h7FF;
  logic [3:0]  left_q = 4'h0;
  assign tick_o   = (div_q == 2'h3);
  assign txd_o    = sh_q[0];
  // Busy until the stop bit has fully left
  assign active_o = (left_q != 4'h0);
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (start_i && left_q == 4'h0) begin
      sh_q   <= {2'h3, data_i, 1'h0};
      left_q <= 4'hB;
    end else if (tick_o && left_q != 4'h0) begin
      sh_q   <= {1'h1, sh_q[10:1]};
      left_q <= left_q - 4'h1;
    end
  end
endmodule // ufc_line_model

//--- ufc_top_chk.sv
`timescale 1ns/100ps
module ufc_top_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic txd_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic host_event_o,
  input wire logic irq_n_oe_o,
  input wire logic tx_enable_o,
  input wire logic core_reset_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence idle_out;
    txd_o && rts_n_o && dtr_n_o && !host_event_o && !irq_n_oe_o;
  endsequence
  // Exactly four cycles, then the core runs again
  sequence soft_run;
    core_reset_o [*4] ##1 !core_reset_o;
  endsequence
  rst_out_a: assert property ($rose(resetn_i) |-> idle_out)
    else $error("outputs not idle after reset");
  soft_len_a: assert property ($rose(core_reset_o) |-> soft_run)
    else $error("soft reset length wrong");
  soft_out_a: assert property (core_reset_o |=> idle_out)
    else $error("soft reset outputs differ");
  tx_off_a: assert property (!tx_enable_o && !$past(tx_enable_o) |-> txd_o)
    else $error("disabled transmitter drives line");
  odrain_a: assert property (irq_n_oe_o == host_event_o)
    else $error("event pin drive mismatch");
  wait_one_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("ready not after one wait");
  pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule // ufc_top_chk
bind ufc_top ufc_top_chk chk_u (.*);

//--- tb.sv
`timescale 1ns/100ps
module tb;
  logic        sys_clk_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1, psel_i = 1'h0;
  logic        penable_i = 1'h0, pwrite_i = 1'h0, tx_fifo_empty_i = 1'h1;
  logic        tx_below_trig_i = 1'h0, sleep_req_i = 1'h0, rx_flow_stop_i = 1'h0;
  logic        rx_i = 1'h1, cts_n_i = 1'h1, dsr_n_i = 1'h1, dcd_n_i = 1'h1, ri_n_i = 1'h1;
  logic        se = 1'h1, start = 1'h0, er, pol, sel, own, md;
  logic [3:0]  pstrb_i = 4'hF;
  logic [7:0]  paddr_i = 8'h00, tx_byte = 8'h00, r8;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic [7:0]  mdl [0:16];
  wire         core_txd_i, tx_active_i, bit_tick_i, pready_o, pslverr_o, txd_o;
  wire         rts_n_o, dtr_n_o, host_event_o, irq_n_o, irq_n_oe_o, tx_enable_o;
  wire         rx_enable_o, core_reset_o, tx_flow_ok_o, sleep_o;
  wire [31:0]  prdata_o;
  wire         tx_shift_empty_i = se & ~tx_active_i;
  integer      err_total = 0, checked = 0, seed = 36, i, n, cnt;
  always #2.5 sys_clk_i = ~sys_clk_i;
  ufc_top dut_u (.*);
  ufc_line_model line_u (.clk_i(sys_clk_i), .start_i(start), .data_i(tx_byte),
    .txd_o(core_txd_i), .active_o(tx_active_i), .tick_o(bit_tick_i));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task apb(input logic w, input logic [5:0] x, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= {x, 2'h0};
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n = n + 1;
    end while (pready_o !== 1'h1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    if (n >= 20) err_total = err_total + 1;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  function automatic logic [7:0] wm(input integer x);
    case (x)
      2, 5, 6, 16: wm = 8'h00;
      12: wm = 8'h0F;
      14: wm = 8'h3F;
      15: wm = 8'h15;
      default: wm = 8'hFF;
    endcase
  endfunction
  task wr(input logic [5:0] x, input logic [7:0] v);
    apb(1'h1, x, {24'h0, v});
    mdl[x] = (mdl[x] & ~wm(x)) | (v & wm(x));
  endtask
  task rc(input logic [5:0] x);
    apb(1'h0, x, 32'h0);
    chk(rd, {24'h0, mdl[x]});
  endtask
  task mrst;
    for (i = 0; i < 17; i = i + 1)
      mdl[i] = 8'h00;
    mdl[2] = 8'h01;
    mdl[5] = 8'h60;
    mdl[7] = 8'h01;
    mdl[16] = 8'h03;
  endtask
  task rall;
    for (i = 0; i < 17; i = i + 1)
      if (i != 6) rc(i[5:0]);
    apb(1'h0, 6'h06, 32'h0);
    chk(rd, {24'h0, ~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i, 4'h0});
    apb(1'h0, 6'h11, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task rst;
    @(posedge sys_clk_i);
    resetn_i <= 1'h0;
    cyc(10);
    @(posedge sys_clk_i);
    resetn_i <= 1'h1;
    mrst;
  endtask
  task go;
    @(posedge sys_clk_i);
    tx_byte <= 8'($random(seed));
    start <= 1'h1;
    @(posedge sys_clk_i);
    start <= 1'h0;
  endtask
  // Bounded wait, a stuck line counts as a mismatch
  task wt(input logic v);
    n = 0;
    while (tx_active_i !== v && n < 100) begin
      cyc(1);
      n = n + 1;
    end
    chk1(tx_active_i, v);
  endtask
  task dirchk(input logic e);
    chk1(sel ? dtr_n_o : rts_n_o, (own & md) ? e : 1'h1);
    chk1(sel ? rts_n_o : dtr_n_o, 1'h1);
  endtask
  task lows;
    cnt = 0;
    repeat (8) begin
      cyc(1);
      cnt = cnt + !sleep_o;
    end
  endtask
  task summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    rst;
    rall;
    $display("reset values done");
    for (i = 0; i < 4; i = i + 1) begin
      r8 = 8'($random(seed));
      wr(6'h0E, r8);
      rc(6'h0E);
      r8 = 8'($random(seed));
      wr(6'h07, r8);
      rc(6'h07);
    end
    $display("register access done");
    go;
    for (i = 0; i < 4; i = i + 1) begin
      wr(6'h0E, {5'h00, i[1:0], 1'h0});
      cyc(2);
      chk1(tx_enable_o, ~i[1]);
      chk1(rx_enable_o, ~i[0]);
    end
    $display("enable bits done");
    wr(6'h0D, 8'h02);
    for (i = 0; i < 6; i = i + 1) begin
      md = (i != 5);
      own = (i != 4);
      pol = i[0];
      sel = i[1];
      wr(6'h0E, {2'h0, pol, own, sel, 2'h0, md});
      wt(1'h0);
      go;
      wt(1'h1);
      cyc(8);
      dirchk(pol);
      wt(1'h0);
      cyc(1);
      dirchk(pol);
      cyc(15);
      dirchk(~pol);
    end
    $display("direction pin done");
    wr(6'h07, 8'hA5);
    wr(6'h0E, 8'h3F);
    wr(6'h0F, 8'h02);
    #1;
    cnt = 0;
    repeat (8) begin
      cnt = cnt + core_reset_o;
      cyc(1);
    end
    chk(cnt, 32'h4);
    mrst;
    rall;
    $display("soft restart done");
    @(posedge sys_clk_i);
    tx_fifo_empty_i <= 1'h0;
    wr(6'h00, 8'h02);
    @(posedge sys_clk_i);
    tx_fifo_empty_i <= 1'h1;
    cyc(4);
    chk1(host_event_o, 1'h1);
    apb(1'h0, 6'h02, 32'h0);
    chk(rd, 32'h2);
    cyc(2);
    chk1(host_event_o, 1'h0);
    @(posedge sys_clk_i);
    tx_fifo_empty_i <= 1'h0;
    se <= 1'h0;
    wr(6'h0F, 8'h01);
    @(posedge sys_clk_i);
    tx_fifo_empty_i <= 1'h1;
    cyc(6);
    chk1(host_event_o, 1'h0);
    @(posedge sys_clk_i);
    se <= 1'h1;
    cyc(4);
    chk1(host_event_o, 1'h1);
    apb(1'h0, 6'h02, 32'h0);
    chk(rd, 32'h2);
    @(posedge sys_clk_i);
    tx_fifo_empty_i <= 1'h0;
    cyc(2);
    @(posedge sys_clk_i);
    tx_below_trig_i <= 1'h1;
    cyc(4);
    chk1(host_event_o, 1'h1);
    wr(6'h00, 8'h00);
    @(posedge sys_clk_i);
    tx_below_trig_i <= 1'h0;
    tx_fifo_empty_i <= 1'h1;
    $display("tx empty event done");
    @(posedge sys_clk_i);
    sleep_req_i <= 1'h1;
    rx_i <= 1'h0;
    cyc(8);
    chk1(sleep_o, 1'h0);
    @(posedge sys_clk_i);
    rx_i <= 1'h1;
    cyc(8);
    chk1(sleep_o, 1'h1);
    @(posedge sys_clk_i);
    rx_i <= 1'h0;
    cyc(8);
    chk1(sleep_o, 1'h0);
    wr(6'h0F, 8'h10);
    cyc(8);
    lows;
    chk(cnt, 32'h0);
    @(posedge sys_clk_i);
    rx_i <= 1'h1;
    lows;
    chk1(cnt != 0, 1'h1);
    @(posedge sys_clk_i);
    sleep_req_i <= 1'h0;
    $display("sleep wake done");
    wr(6'h09, 8'h80);
    @(posedge sys_clk_i);
    dsr_n_i <= 1'h0;
    cyc(6);
    chk1(tx_flow_ok_o, 1'h0);
    wr(6'h0F, 8'h04);
    cyc(6);
    chk1(tx_flow_ok_o, 1'h1);
    @(posedge sys_clk_i);
    dsr_n_i <= 1'h1;
    cts_n_i <= 1'h0;
    cyc(6);
    chk1(tx_flow_ok_o, 1'h0);
    wr(6'h04, 8'h03);
    wr(6'h09, 8'hC0);
    @(posedge sys_clk_i);
    rx_flow_stop_i <= 1'h1;
    cyc(3);
    chk({30'h0, rts_n_o, dtr_n_o}, 32'h1);
    @(posedge sys_clk_i);
    ce_i <= 1'h0;
    rx_flow_stop_i <= 1'h0;
    cyc(4);
    chk({30'h0, rts_n_o, dtr_n_o}, 32'h1);
    @(posedge sys_clk_i);
    ce_i <= 1'h1;
    cyc(2);
    chk({30'h0, rts_n_o, dtr_n_o}, 32'h0);
    $display("flow swap done");
    rst;
    cyc(1);
    chk({27'h0, txd_o, rts_n_o, dtr_n_o, host_event_o, irq_n_oe_o}, 32'h1C);
    rall;
    $display("second reset done");
    summarize;
  end
endmodule // tb
